// ==== hdl/output_alarm_defines.vh ====
// Constants for the output-enable and alarm control block
// Assumes a 250 MHz system clock and plain register port access
`ifndef OUTPUT_ALARM_DEFINES_VH
`define OUTPUT_ALARM_DEFINES_VH

// Register offsets (byte addresses, word aligned)
`define ADDR_CONTROL     8'h00
`define ADDR_STATUS      8'h04
`define ADDR_ALARM       8'h08
`define ADDR_OV_LIMIT    8'h0c
`define ADDR_OC_LIMIT    8'h10
`define ADDR_OP_LIMIT    8'h14
`define ADDR_COMMAND     8'h18

// Control register fields
`define CTL_INVERT       0
`define CTL_BEEP_EN      1
`define CTL_PF_RESTORE   2
`define CTL_RESET_VALUE  32'h0000_0000

// Command register fields (write only, self clearing)
`define CMD_ON           0
`define CMD_OFF          1
`define CMD_ACK          2

// Alarm bit positions
`define ALM_OV           0
`define ALM_OC           1
`define ALM_OP           2
`define ALM_PF           3
`define ALM_OT           4

// Thresholds: 16 bit scale, nominal = 16'h8000, 110 percent default
`define LIMIT_WIDTH      16
`define LIMIT_DEFAULT    16'h8ccc

// Beep length in microseconds and derived cycle count at 250 MHz
`define CLOCK_MHZ        250
`define BEEP_US          100
`define BEEP_CYCLES      (`BEEP_US * `CLOCK_MHZ)

`endif

// ==== hdl/output_enable_alarm_control.v ====
// Output enable decision and protection alarm latching for a DC supply
// Assumes pin inputs are asynchronous; panel buttons and limits are clock domain
`timescale 1ns/1ps
`default_nettype none
`include "output_alarm_defines.vh"

module output_enable_alarm_control #(
    parameter integer BEEP_CYCLES = `BEEP_CYCLES
) (
    input  wire        clock,                   // System clock, 250 MHz
    input  wire        rst_n,                   // Synchronous reset, active low
    input  wire        output_standby_input,    // Standby pin, asynchronous
    input  wire        remote_select_n,         // Remote select pin, low = remote
    input  wire        panel_onoff,             // On/off button pulse
    input  wire        panel_enter,             // Enter button pulse
    input  wire        menu_request,            // Menu button pulse
    input  wire [15:0] voltage_meas,            // Output voltage, scaled
    input  wire [15:0] current_meas,            // Output current, scaled
    input  wire [15:0] power_meas,              // Output power, scaled
    input  wire        supply_fault,            // Supply fault indication
    input  wire        temp_limit,              // Temperature limit indication
    input  wire        user_event,              // User-defined event pulse
    input  wire [7:0]  address,                 // Register address
    input  wire [31:0] write_data,              // Register write data
    input  wire        write_strobe,            // Register write strobe
    input  wire        read_strobe,             // Register read strobe
    output reg  [31:0] read_data,               // Register read data
    output reg         output_enable,           // DC output on
    output reg         menu_open,               // Configuration menu active
    output reg         reject_popup,            // Switch-on rejection pulse
    output reg         beep,                    // Acoustic signal
    output wire        alarm_indicate,          // Any latched alarm
    output reg         overvoltage_alarm,       // Over-voltage alarm pin
    output reg         heat_supply_alarm_output // Over-heat or supply fault pin
);

    // ------------------------------------------------------------------
    // Operating notes
    // ------------------------------------------------------------------
    // Priority of the output decision, highest first:
    //   1. Any latched or newly raised alarm forces the output off.
    //   2. Remote mode copies the effective standby level.
    //   3. Supply fault recovery may restore the output once.
    //   4. Local mode applies the standby lock and its pending restore.
    //   5. Local mode applies panel and command on/off requests.
    // Only one branch acts per cycle, so a request that coincides with
    // a higher-priority event is dropped rather than queued.
    //
    // Pin timing: a pin edge reaches the second synchroniser stage after
    // two edges and moves the output on the third. Controllers that
    // change a pin and then issue a command must allow for this delay,
    // or the command is judged against the old pin level.
    //
    // Configuration and limit writes are dropped while the output is on.
    // This keeps threshold changes out of a running output, matching the
    // menu gate; software sees the old value on read-back.
    //
    // Command writes are always taken. The on, off and acknowledge bits
    // are pulses that last only the write cycle; nothing is stored.
    //
    // Acknowledge clears only those alarm bits whose cause has gone.
    // A cause present in the same cycle keeps its bit set, so an
    // acknowledge can never hide a live fault.
    //
    // Remote acknowledge needs the standby pin low for a long time.
    // The low-time counter saturates and is cleared when the pin returns
    // high, so a short glitch never counts as an acknowledge.
    //
    // The beeper restarts its count on every new alarm or user event.
    // A burst of events therefore stretches one tone instead of
    // producing several short ones.
    //
    // Limit comparisons use greater-or-equal, so an output that sits
    // exactly on its threshold raises the alarm.
    //
    // The combined heat and supply pin and the over-voltage pin are
    // registered one cycle after the alarm bits, which keeps them free
    // of decode glitches on the way to the connector.
    //
    // The menu flag only reflects the gate; navigation lives elsewhere.
    // Turning the output on closes the menu so that a running output
    // never shows an open configuration page.
    //
    // Rejections set a sticky status bit and a one-cycle popup pulse.
    // The sticky bit clears only when a local on request switches the output on, so
    // software can poll for a rejection it missed.

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg [1:0] standby_sync_reg;
    reg [1:0] remote_sync_reg;

    // Two flip-flops per pin; only the second stage is read
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            standby_sync_reg <= 2'h3;
            remote_sync_reg  <= 2'h3;
        end
        else
        begin
            standby_sync_reg <= {standby_sync_reg[0], output_standby_input};
            remote_sync_reg  <= {remote_sync_reg[0], remote_select_n};
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    reg [2:0]  control_reg;
    reg [15:0] ov_limit_reg;
    reg [15:0] oc_limit_reg;
    reg [15:0] op_limit_reg;
    reg [4:0]  alarm_reg;
    reg        rejected_reg;
    reg        restore_pending_reg;
    reg        pf_resume_reg;
    localparam [31:0] CTL_RESET = `CTL_RESET_VALUE;

    wire invert     = control_reg[`CTL_INVERT];
    wire remote     = ~remote_sync_reg[1];
    wire standby_on = standby_sync_reg[1] ^ invert;
    wire cfg_write  = write_strobe & ~output_enable;

    // Command decode shared by the output and alarm logic
    wire cmd_hit = write_strobe & (address == `ADDR_COMMAND);
    wire cmd_on  = cmd_hit & write_data[`CMD_ON];
    wire cmd_off = cmd_hit & write_data[`CMD_OFF];
    wire cmd_ack = cmd_hit & write_data[`CMD_ACK];

    // Configuration and thresholds; writable only with output off
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            control_reg  <= CTL_RESET[2:0];
            ov_limit_reg <= `LIMIT_DEFAULT;
            oc_limit_reg <= `LIMIT_DEFAULT;
            op_limit_reg <= `LIMIT_DEFAULT;
        end
        else if (cfg_write)
        begin
            case (address)
                `ADDR_CONTROL:  control_reg  <= write_data[2:0];
                `ADDR_OV_LIMIT: ov_limit_reg <= write_data[15:0];
                `ADDR_OC_LIMIT: oc_limit_reg <= write_data[15:0];
                `ADDR_OP_LIMIT: op_limit_reg <= write_data[15:0];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge clock)
    begin
        if (!rst_n)
            read_data <= 32'h0000_0000;
        else if (read_strobe)
        begin
            case (address)
                `ADDR_CONTROL:  read_data <= {29'h0, control_reg};
                `ADDR_STATUS:   read_data <= {26'h0, pf_resume_reg, rejected_reg,
                                              restore_pending_reg, remote,
                                              standby_on, output_enable};
                `ADDR_ALARM:    read_data <= {27'h0, alarm_reg};
                `ADDR_OV_LIMIT: read_data <= {16'h0, ov_limit_reg};
                `ADDR_OC_LIMIT: read_data <= {16'h0, oc_limit_reg};
                `ADDR_OP_LIMIT: read_data <= {16'h0, op_limit_reg};
                default:        read_data <= 32'h0000_0000;
            endcase
        end
        else
            read_data <= 32'h0000_0000;
    end

    // ------------------------------------------------------------------
    // Alarm detection and latching
    // ------------------------------------------------------------------
    wire [4:0] cause;
    assign cause[`ALM_OV] = voltage_meas >= ov_limit_reg;
    assign cause[`ALM_OC] = current_meas >= oc_limit_reg;
    assign cause[`ALM_OP] = power_meas   >= op_limit_reg;
    assign cause[`ALM_PF] = supply_fault;
    assign cause[`ALM_OT] = temp_limit;

    // Remote acknowledge: standby low for 50 ms then high again
    localparam integer ACK_CYCLES = 50000 * `CLOCK_MHZ;
    reg [23:0] low_count_reg;
    reg        low_long_reg;
    reg        standby_prev_reg;
    wire       remote_ack = remote & standby_sync_reg[1] & ~standby_prev_reg
                            & low_long_reg;

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            low_count_reg    <= 24'h000000;
            low_long_reg     <= 1'b0;
            standby_prev_reg <= 1'b1;
        end
        else
        begin
            standby_prev_reg <= standby_sync_reg[1];
            if (standby_sync_reg[1])
            begin
                low_count_reg <= 24'h000000;
                if (standby_prev_reg)
                    low_long_reg <= 1'b0;
            end
            else if (low_count_reg == ACK_CYCLES[23:0] - 24'h1)
                low_long_reg <= 1'b1;
            else
                low_count_reg <= low_count_reg + 24'h1;
        end
    end

    // Manual acknowledge by button, or software acknowledge command
    wire ack = (~remote & (panel_enter | panel_onoff)) | cmd_ack | remote_ack;
    wire any_alarm = |alarm_reg;
    wire new_alarm = |(cause & ~alarm_reg);

    // Latched bits: a live cause sets and blocks the clear
    always @(posedge clock)
    begin
        if (!rst_n)
            alarm_reg <= 5'h00;
        else if (ack)
            alarm_reg <= cause;
        else
            alarm_reg <= alarm_reg | cause;
    end

    assign alarm_indicate = any_alarm;

    // Alarm pins follow the present alarm state
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            overvoltage_alarm        <= 1'b0;
            heat_supply_alarm_output <= 1'b0;
        end
        else
        begin
            overvoltage_alarm        <= alarm_reg[`ALM_OV];
            heat_supply_alarm_output <= alarm_reg[`ALM_PF] | alarm_reg[`ALM_OT];
        end
    end

    // ------------------------------------------------------------------
    // Output enable decision
    // ------------------------------------------------------------------
    wire on_req     = ~remote & (panel_onoff | cmd_on);
    wire toggle_req = ~remote & (panel_onoff | cmd_off);
    wire pf_clear   = pf_resume_reg & ~cause[`ALM_PF] & ~any_alarm;

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            output_enable       <= 1'b0;
            restore_pending_reg <= 1'b0;
            rejected_reg        <= 1'b0;
            reject_popup        <= 1'b0;
            pf_resume_reg       <= 1'b0;
        end
        else
        begin
            reject_popup <= 1'b0;
            if (cause[`ALM_PF])
                pf_resume_reg <= control_reg[`CTL_PF_RESTORE] &
                                 (output_enable | pf_resume_reg);
            else if (pf_clear)
                pf_resume_reg <= 1'b0;
            if (any_alarm | new_alarm)
            begin
                output_enable       <= 1'b0;
                restore_pending_reg <= 1'b0;
            end
            else if (remote)
            begin
                output_enable       <= standby_on;
                restore_pending_reg <= 1'b0;
            end
            else if (pf_clear)
                output_enable <= standby_on;
            else if (!standby_on)
            begin
                if (output_enable)
                begin
                    output_enable       <= 1'b0;
                    restore_pending_reg <= 1'b1;
                end
                else if (restore_pending_reg & (panel_onoff | cmd_on | cmd_off))
                    restore_pending_reg <= 1'b0;
                else if (on_req)
                begin
                    reject_popup <= 1'b1;
                    rejected_reg <= 1'b1;
                end
            end
            else if (restore_pending_reg)
            begin
                output_enable       <= 1'b1;
                restore_pending_reg <= 1'b0;
            end
            else if (output_enable & toggle_req)
                output_enable <= 1'b0;
            else if (!output_enable & on_req)
            begin
                output_enable <= 1'b1;
                rejected_reg  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Menu gate and beeper
    // ------------------------------------------------------------------
    reg [31:0] beep_count_reg;

    // Menu opens only with output off and closes when output turns on
    always @(posedge clock)
    begin
        if (!rst_n)
            menu_open <= 1'b0;
        else if (output_enable)
            menu_open <= 1'b0;
        else if (menu_request)
            menu_open <= ~menu_open;
    end

    // Beep for a fixed time on a new alarm or user event when enabled
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            beep           <= 1'b0;
            beep_count_reg <= 32'h0000_0000;
        end
        else if (control_reg[`CTL_BEEP_EN] & (new_alarm | user_event))
        begin
            beep           <= 1'b1;
            beep_count_reg <= BEEP_CYCLES;
        end
        else if (beep_count_reg != 32'h0000_0000)
            beep_count_reg <= beep_count_reg - 32'h1;
        else
            beep <= 1'b0;
    end

endmodule // output_enable_alarm_control
`default_nettype wire

// ==== test/output_alarm_monitor.sv ====
// Checker on the top ports of the output enable and alarm block
// Assumes two-flop pin synchronisers and config writes taken only while off
`timescale 1ns/1ps
`default_nettype none
`include "output_alarm_defines.vh"
module output_alarm_monitor (
    input wire logic        clock,                   // Clock
    input wire logic        rst_n,                   // Reset, active low
    input wire logic        output_standby_input,    // Standby pin
    input wire logic        remote_select_n,         // Remote select pin
    input wire logic        menu_request,            // Menu press
    input wire logic [15:0] voltage_meas,            // Voltage
    input wire logic        supply_fault,            // Supply fault
    input wire logic        temp_limit,              // Temperature limit
    input wire logic [7:0]  address,                 // Address
    input wire logic [31:0] write_data,              // Write data
    input wire logic        write_strobe,            // Write strobe
    input wire logic        output_enable,           // DC output on
    input wire logic        menu_open,               // Menu active
    input wire logic        reject_popup,            // Rejection pulse
    input wire logic        beep,                    // Beep
    input wire logic        alarm_indicate,          // Any alarm
    input wire logic        overvoltage_alarm,       // Over-voltage pin
    input wire logic        heat_supply_alarm_output // Heat or supply pin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [1:0] sb_sync_reg;
    logic [1:0] rm_sync_reg;
    logic       invert_reg;
    wire        eff_off = (sb_sync_reg[1] == invert_reg);
    wire        remote  = !rm_sync_reg[1];
    // Shadow pin synchronisers and polarity setting
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            {sb_sync_reg, rm_sync_reg, invert_reg} <= 5'h1e;
        else
        begin
            sb_sync_reg <= {sb_sync_reg[0], output_standby_input};
            rm_sync_reg <= {rm_sync_reg[0], remote_select_n};
            if (write_strobe && address == `ADDR_CONTROL && !output_enable)
                invert_reg <= write_data[`CTL_INVERT];
        end
    end
    sequence s_off_level;
        eff_off [*2];
    endsequence
    sequence s_remote_on;
        (remote && !eff_off && !alarm_indicate) [*3];
    endsequence
    a_off_level_blocks: assert property (s_off_level |-> !output_enable)
        else $error("output on at off level");
    a_remote_follows_pin: assert property (s_remote_on |-> output_enable)
        else $error("remote output not on");
    a_alarm_forces_off: assert property (alarm_indicate [*3] |-> !output_enable)
        else $error("output on during alarm");
    a_ov_raises_pin: assert property ((voltage_meas >= `LIMIT_DEFAULT) [*2] |-> ##[0:2] overvoltage_alarm)
        else $error("over-voltage pin late");
    a_heat_raises_pin: assert property ((supply_fault || temp_limit) |-> ##[1:3] heat_supply_alarm_output)
        else $error("heat pin late");
    a_live_alarm_holds: assert property ((temp_limit || supply_fault) && alarm_indicate |=> alarm_indicate)
        else $error("live alarm cleared");
    a_beep_length: assert property ($rose(beep) |-> beep [*4] ##[1:4] !beep)
        else $error("beep length wrong");
    a_popup_one_cycle: assert property (reject_popup |=> !reject_popup)
        else $error("popup longer than a cycle");
    a_menu_only_off: assert property ($rose(menu_open) |-> $past(menu_request) && !$past(output_enable))
        else $error("menu opened while on");
endmodule // output_alarm_monitor
bind output_enable_alarm_control output_alarm_monitor output_alarm_monitor_inst (
    .clock(clock), .rst_n(rst_n), .output_standby_input(output_standby_input),
    .remote_select_n(remote_select_n), .menu_request(menu_request),
    .voltage_meas(voltage_meas), .supply_fault(supply_fault), .temp_limit(temp_limit),
    .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .output_enable(output_enable), .menu_open(menu_open), .reject_popup(reject_popup),
    .beep(beep), .alarm_indicate(alarm_indicate), .overvoltage_alarm(overvoltage_alarm),
    .heat_supply_alarm_output(heat_supply_alarm_output));
`default_nettype wire

// ==== test/standby_contact.sv ====
// Model of the external contacts on the standby and remote-select pins
// Assumes open contacts read high through the pin pull-ups
`timescale 1ns/1ps
`default_nettype none
module standby_contact (
    input  wire logic clock,               // Bench clock
    input  wire logic pull_standby,        // Close standby contact
    input  wire logic pull_remote,         // Close remote contact
    output var  logic standby_pin = 1'b1,  // Standby pin level
    output var  logic remote_pin_n = 1'b1  // Remote select level
);
    // Closed contact pulls low, open contact floats high
    always @(posedge clock)
    begin
        standby_pin  <= !pull_standby;
        remote_pin_n <= !pull_remote;
    end
endmodule // standby_contact
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the output enable and alarm block
// Assumes the design header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "output_alarm_defines.vh"
module tb;
    logic        clock = 0, rst_n = 0, pull_sb = 0, pull_rm = 0, user_event = 0;
    logic        panel_onoff = 0, panel_enter = 0, menu_request = 0;
    logic        supply_fault = 0, temp_limit = 0, write_strobe = 0, read_strobe = 0;
    logic [15:0] voltage_meas = 16'h0, current_meas = 16'h0, power_meas = 16'h0;
    logic [7:0]  address = 8'h0;
    logic [31:0] write_data = 32'h0, read_data;
    logic        sb_pin, rm_pin_n, oe, menu_open, reject_popup, beep, alarm_indicate;
    logic        ov_pin, heat_pin;
    int          n_fail = 0, comparisons = 0, popups = 0, beeps = 0, p0, b0, k;
    initial forever #2 clock = ~clock;
    standby_contact standby_contact_inst (.clock(clock), .pull_standby(pull_sb),
        .pull_remote(pull_rm), .standby_pin(sb_pin), .remote_pin_n(rm_pin_n));
    output_enable_alarm_control #(.BEEP_CYCLES(4)) output_enable_alarm_control_inst (
        .clock(clock), .rst_n(rst_n), .output_standby_input(sb_pin),
        .remote_select_n(rm_pin_n), .panel_onoff(panel_onoff), .panel_enter(panel_enter),
        .menu_request(menu_request), .voltage_meas(voltage_meas), .current_meas(current_meas),
        .power_meas(power_meas), .supply_fault(supply_fault), .temp_limit(temp_limit),
        .user_event(user_event), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .output_enable(oe), .menu_open(menu_open), .reject_popup(reject_popup), .beep(beep),
        .alarm_indicate(alarm_indicate), .overvoltage_alarm(ov_pin),
        .heat_supply_alarm_output(heat_pin));
    // Count rejection pulses and beep cycles
    always @(posedge clock)
    begin
        popups <= popups + reject_popup;
        beeps  <= beeps + beep;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {write_strobe, address, write_data} <= {1'b1, a, d};
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clock);
        {read_strobe, address} <= {1'b1, a};
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 chk(what, exp, read_data);
    endtask
    // Button pulse: 0 on/off, 1 enter, 2 menu
    task automatic press(input int b);
        @(posedge clock);
        {panel_onoff, panel_enter, menu_request} <= {b == 0, b == 1, b == 2};
        @(posedge clock);
        {panel_onoff, panel_enter, menu_request} <= 3'h0;
    endtask
    task automatic pin(input logic sb, input logic rm);
        @(posedge clock);
        {pull_sb, pull_rm} <= {sb, rm};
        repeat (4) @(posedge clock);
    endtask
    task automatic expect_oe(input logic v, input string what);
        for (int i = 0; i < 12 && oe !== v; i++) @(posedge clock);
        #1 chk(what, {31'h0, v}, {31'h0, oe});
    endtask
    task automatic hold_oe(input logic v, input string what);
        repeat (8) @(posedge clock);
        #1 chk(what, {31'h0, v}, {31'h0, oe});
    endtask
    task automatic cause(input int c, input logic v);
        @(posedge clock);
        case (c)
            0: voltage_meas <= v ? 16'h9000 : 16'h4000;
            1: current_meas <= v ? 16'h9000 : 16'h4000;
            2: power_meas <= v ? 16'h9000 : 16'h4000;
            3: supply_fault <= v;
            default: temp_limit <= v;
        endcase
    endtask
    task automatic summarize;
        $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #80000;
        n_fail++;
        summarize();
    end
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(`ADDR_CONTROL, `CTL_RESET_VALUE, "control");
        rd(`ADDR_OV_LIMIT, {16'h0, `LIMIT_DEFAULT}, "ov_limit");
        rd(`ADDR_OP_LIMIT, {16'h0, `LIMIT_DEFAULT}, "op_limit");
        wr(`ADDR_OC_LIMIT, 32'h0000_8800);
        rd(`ADDR_OC_LIMIT, 32'h0000_8800, "oc_limit");
        rd(8'h1c, 32'h0, "unmapped");
        $display("Test registers done");
        wr(`ADDR_COMMAND, 32'h1);
        expect_oe(1'b1, "cmd_on");
        press(0);
        expect_oe(1'b0, "panel_off");
        press(0);
        expect_oe(1'b1, "panel_on");
        pin(1, 0);
        expect_oe(1'b0, "lock_off");
        pin(0, 0);
        expect_oe(1'b1, "restore");
        pin(1, 0);
        expect_oe(1'b0, "relock");
        press(0);
        pin(0, 0);
        hold_oe(1'b0, "cancelled");
        pin(1, 0);
        p0 = popups;
        wr(`ADDR_COMMAND, 32'h1);
        hold_oe(1'b0, "rejected");
        chk("popup", p0 + 1, popups);
        rd(`ADDR_STATUS, 32'h10, "status_rej");
        pin(0, 0);
        $display("Test local lock done");
        wr(`ADDR_CONTROL, 32'h1);
        wr(`ADDR_COMMAND, 32'h1);
        hold_oe(1'b0, "inv_high_off");
        pin(1, 0);
        wr(`ADDR_COMMAND, 32'h1);
        expect_oe(1'b1, "inv_low_on");
        wr(`ADDR_CONTROL, 32'h2);
        rd(`ADDR_CONTROL, 32'h1, "cfg_locked");
        press(2);
        hold_oe(1'b1, "menu_while_on");
        chk("menu_on", 0, menu_open);
        wr(`ADDR_COMMAND, 32'h2);
        expect_oe(1'b0, "cmd_off");
        press(2);
        repeat (3) @(posedge clock);
        chk("menu_off", 1, menu_open);
        press(2);
        wr(`ADDR_CONTROL, 32'h2);
        pin(0, 0);
        $display("Test polarity and menu done");
        for (k = 0; k < 5; k++)
        begin
            wr(`ADDR_COMMAND, 32'h1);
            expect_oe(1'b1, "pre_alarm_on");
            b0 = beeps;
            cause(k, 1'b1);
            expect_oe(1'b0, "alarm_off");
            rd(`ADDR_ALARM, 32'h1 << k, "alarm_bit");
            chk("ov_pin", k == 0, ov_pin);
            chk("heat_pin", k >= 3, heat_pin);
            chk("beep", 1, beeps > b0);
            wr(`ADDR_COMMAND, 32'h4);
            rd(`ADDR_ALARM, 32'h1 << k, "ack_refused");
            cause(k, 1'b0);
            repeat (4) @(posedge clock);
            if (k[0])
                wr(`ADDR_COMMAND, 32'h4);
            else
                press(1);
            rd(`ADDR_ALARM, 32'h0, "alarm_clear");
        end
        $display("Test alarms done");
        pin(0, 1);
        expect_oe(1'b1, "remote_open_on");
        rd(`ADDR_STATUS, 32'h7, "status_remote");
        press(0);
        hold_oe(1'b1, "remote_panel");
        pin(1, 1);
        expect_oe(1'b0, "remote_off");
        wr(`ADDR_COMMAND, 32'h1);
        hold_oe(1'b0, "remote_cmd");
        pin(0, 1);
        expect_oe(1'b1, "remote_on");
        pin(0, 0);
        $display("Test remote done");
        summarize();
    end
endmodule // tb
`default_nettype wire
